// *** design/scs_pkg.sv ***
// shared constants and carriers for the scan-cycle sequencer
package scs_pkg;
    // ==========================================================
    // timing
    // ==========================================================
    localparam int CLK_MHZ         = 125;
    localparam int MS_CYCLES       = CLK_MHZ * 1000;
    localparam int LIMITED_WIN_MS  = 6;
    localparam int RTC_WIN_MS      = 400;
    localparam int WATCHDOG_MS     = 500;
    localparam int CONST_MIN_MS    = 5;
    localparam int CONST_MAX_MS    = 500;
    localparam int BLINK_WINDOW_MS = 5000;
    localparam int HOLD_MS         = 500;
    localparam int BLINK_HALF_MS   = 250;
    localparam int MSW             = 13;

    // ==========================================================
    // scan phases, one-hot
    // ==========================================================
    typedef enum logic [7:0] {
        PH_HOUSE  = 8'h01,
        PH_INPUT  = 8'h02,
        PH_EXEC   = 8'h04,
        PH_OUTPUT = 8'h08,
        PH_TOOL   = 8'h10,
        PH_SYS    = 8'h20,
        PH_DIAG   = 8'h40,
        PH_WAIT   = 8'h80
    } scs_phase_t;

    typedef enum logic [3:0] {
        MD_RUN      = 4'h1,
        MD_STOP_IO  = 4'h2,
        MD_STOP_NIO = 4'h4,
        MD_FAULT    = 4'h8
    } scs_mode_t;

    // configuration carrier
    typedef struct packed {
        logic             const_scan_dflt;
        logic [MSW-1:0]   const_len_ms;
        logic             rtc_mode;
        logic             stop_io_scan;
        logic             sw_mode_en;
        logic             sw_protect_en;
    } scs_cfg_t;

    // phase-done handshakes from the outside world
    typedef struct packed {
        logic input_done;
        logic exec_done;
        logic output_done;
        logic tool_idle;
        logic sys_idle;
        logic diag_done;
    } scs_done_t;
endpackage : scs_pkg

// *** design/scs_ms_tick.sv ***
// free-running millisecond tick divider
`timescale 1ns/100ps
module scs_ms_tick #(
    parameter int DIV = scs_pkg::MS_CYCLES
) (
    input  wire logic clk_i,    // system clock
    input  wire logic rst_n_i,  // async reset, active low
    output logic      tick_o    // one-cycle pulse every DIV clocks
);
    import scs_pkg::*;

    logic [31:0] cnt_r;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r  <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            tick_o <= (cnt_r == 32'(DIV - 1));
            cnt_r  <= (cnt_r == 32'(DIV - 1)) ? '0 : cnt_r + 32'h1;
        end
    end
endmodule : scs_ms_tick

// *** design/scs_sequencer.sv ***
// scan-cycle sequencer: phases, windows, watchdog, constant scan, run/stop switch
// Function
// - phases run housekeeping, input, exec, output, tool (if attached), system, diagnostics
// - limited mode: window closes when idle or after 6 ms
// - run-to-completion: window runs until idle, capped at 400 ms
// - standard mode watchdog of 500 ms restarts at each scan start
// - watchdog expiry: OK off for one cycle (relit at next housekeeping), reset pulse, fault logged, enter stop
// - constant-scan length accepted from 5 to 500 ms
// - expired constant timer never cuts a phase short
// - scan after an overrun logs an overrun alarm
// - scan after that alarm sets the overrun flag
// - flag clears when scan fits or constant mode is off
// - constant-scan default edited only while stopped, applied on store
// - stop states skip execution; io scan per configuration
// - while stopped, tool and system windows keep running
// - service call 13 stops at end of current scan, outputs default, diag logged
// - after config reset, switch selects mode and protection is off
// - switch to run with only non-fatal faults enters run from a stop state other than fault-stop, faults kept
// - fault-stop plus fatal fault and switch to run blinks 5 s
// - run 0.5 s, stop 0.5 s, run again clears faults and runs
// - toggle not finished in 5 s: indicator off, stay fault-stop
// - switch protection blocks memory writes and forcing while the switch is at stop
// - constant mode housekeeping waits for length or sets flag
// - switch in stop with selection enabled refuses run
// - run-to-stop toggle enters stop with or without io per config
`timescale 1ns/100ps
module scs_sequencer #(
    parameter int WD_MS   = scs_pkg::WATCHDOG_MS,
    parameter int BLINK_MS = scs_pkg::BLINK_WINDOW_MS,
    parameter int HOLD_T  = scs_pkg::HOLD_MS,
    parameter int TICK_DIV = scs_pkg::MS_CYCLES
) (
    input  wire logic              clk_i,          // system clock
    input  wire logic              rst_n_i,        // async reset, active low
    input  scs_pkg::scs_cfg_t      cfg_i,          // configuration inputs
    input  wire logic              cfg_store_i,    // store pulse for configuration
    input  wire logic              cfg_reset_i,    // configuration reset pulse
    input  scs_pkg::scs_done_t     done_i,         // phase completion signals
    input  wire logic              tool_attached_i,// programming tool present
    input  wire logic              sw_run_i,       // mode switch at run
    input  wire logic              svc_stop_i,     // program_service_call 13 pulse
    input  wire logic              run_req_i,      // tool run request
    input  wire logic              stop_req_i,     // tool stop request
    input  wire logic              fatal_fault_i,  // fatal faults present
    input  wire logic              mem_wr_req_i,   // tool write/force request
    output scs_pkg::scs_phase_t    phase_o,        // current phase
    output scs_pkg::scs_mode_t     mode_o,         // run or stop state
    output logic                   scan_start_o,   // pulse at scan start
    output logic                   scan_overrun_flag_o, // overrun flag to logic
    output logic                   ovr_alarm_o,    // pulse: overrun alarm logged
    output logic                   wd_fault_o,     // pulse: watchdog fault logged
    output logic                   wd_reset_o,     // pulse: self reset
    output logic                   diag_log_o,     // pulse: stop-call diagnostic
    output logic                   faults_clr_o,   // pulse: clear fault table
    output logic                   out_default_o,  // outputs at defaults
    output logic                   ok_led_o,       // ok indicator
    output logic                   run_led_o,      // run indicator
    output logic                   mem_wr_ok_o     // memory write/force permitted
);
    import scs_pkg::*;

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        scs_phase_t     phase;
        scs_mode_t      mode;
        logic [MSW-1:0] scan_ms;
        logic [MSW-1:0] win_ms;
        logic [MSW-1:0] blink_ms;
        logic [MSW-1:0] hold_ms;
        logic [1:0]     tstep;
        logic           blinking;
        logic           const_act;
        logic [MSW-1:0] const_len;
        logic           ovr_seen;
        logic           alarm_done;
        logic           stop_pend;
        logic           sw_prev;
        logic           sw_mode_en;
        logic           sw_prot_en;
        logic           scan_start;
        logic           flag;
        logic           alarm;
        logic           wd_fault;
        logic           wd_rst;
        logic           diag;
        logic           fclr;
        logic           out_dflt;
        logic           ok_led;
        logic           run_led;
        logic           wr_ok;
    } scs_state_t;

    scs_state_t s_r;
    scs_state_t s_nxt;
    logic       tick;
    logic       sw_s1_r;
    logic       sw_s2_r;

    scs_ms_tick #(.DIV(TICK_DIV)) u_tick (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .tick_o  (tick)
    );

    // switch synchroniser
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sw_s1_r <= 1'b0;
            sw_s2_r <= 1'b0;
        end
        else
        begin
            sw_s1_r <= sw_run_i;
            sw_s2_r <= sw_s1_r;
        end
    end

    localparam logic [MSW-1:0] WIN_LIM = MSW'(LIMITED_WIN_MS);
    localparam logic [MSW-1:0] WIN_RTC = MSW'(RTC_WIN_MS);
    localparam logic [MSW-1:0] WD_LEN  = MSW'(WD_MS);
    localparam logic [MSW-1:0] BLK_LEN = MSW'(BLINK_MS);
    localparam logic [MSW-1:0] HLD_LEN = MSW'(HOLD_T);
    localparam logic [MSW-1:0] C_MIN   = MSW'(CONST_MIN_MS);
    localparam logic [MSW-1:0] C_MAX   = MSW'(CONST_MAX_MS);
    localparam logic [MSW-1:0] BLK_HF  = MSW'(BLINK_HALF_MS);

    // ==========================================================
    // next state
    // ==========================================================
    always_comb
    begin
        logic stopped;
        logic win_end;
        logic idle;
        logic sw_rise;
        logic sw_fall;
        logic [MSW-1:0] win_cap;
        stopped = 1'b0;
        win_end = 1'b0;
        idle    = 1'b0;
        sw_rise = 1'b0;
        sw_fall = 1'b0;
        win_cap = '0;
        s_nxt   = s_r;
        s_nxt.scan_start = 1'b0;
        s_nxt.alarm      = 1'b0;
        s_nxt.wd_fault   = 1'b0;
        s_nxt.wd_rst     = 1'b0;
        s_nxt.diag       = 1'b0;
        s_nxt.fclr       = 1'b0;
        stopped = (s_r.mode != MD_RUN);
        sw_rise = sw_s2_r && !s_r.sw_prev;
        sw_fall = !sw_s2_r && s_r.sw_prev;
        s_nxt.sw_prev = sw_s2_r;

        // millisecond counters
        if (tick)
        begin
            if (s_r.scan_ms != '1)
                s_nxt.scan_ms = s_r.scan_ms + MSW'(1);
            if (s_r.win_ms != '1)
                s_nxt.win_ms = s_r.win_ms + MSW'(1);
            if (s_r.hold_ms != '1)
                s_nxt.hold_ms = s_r.hold_ms + MSW'(1);
        end

        // configuration
        if (cfg_reset_i)
        begin
            s_nxt.sw_mode_en = 1'b1;
            s_nxt.sw_prot_en = 1'b0;
        end
        else if (cfg_store_i && stopped)
        begin
            s_nxt.sw_mode_en = cfg_i.sw_mode_en;
            s_nxt.sw_prot_en = cfg_i.sw_protect_en;
            s_nxt.const_act  = cfg_i.const_scan_dflt;
            if (cfg_i.const_len_ms >= C_MIN && cfg_i.const_len_ms <= C_MAX)
                s_nxt.const_len = cfg_i.const_len_ms;
        end
        if (!s_r.const_act)
            s_nxt.flag = 1'b0;

        // phase sequencing
        win_cap = cfg_i.rtc_mode ? WIN_RTC : WIN_LIM;
        unique case (s_r.phase)
            PH_HOUSE:
            begin
                s_nxt.scan_start = 1'b1;
                s_nxt.scan_ms    = '0;
                if (s_r.ovr_seen && !s_r.alarm_done)
                begin
                    s_nxt.alarm      = 1'b1;
                    s_nxt.alarm_done = 1'b1;
                    s_nxt.ovr_seen   = 1'b0;
                end
                else if (s_r.alarm_done)
                begin
                    s_nxt.flag       = s_r.const_act;
                    s_nxt.alarm_done = 1'b0;
                end
                s_nxt.phase = PH_INPUT;
            end
            PH_INPUT:
                if (done_i.input_done || (stopped && !cfg_i.stop_io_scan))
                    s_nxt.phase = stopped ? PH_OUTPUT : PH_EXEC;
            PH_EXEC:
                // a stop taken mid-execution leaves the phase at once
                if (done_i.exec_done || stopped)
                    s_nxt.phase = PH_OUTPUT;
            PH_OUTPUT:
                if (done_i.output_done || s_r.out_dflt)
                begin
                    s_nxt.win_ms = '0;
                    s_nxt.phase  = tool_attached_i ? PH_TOOL : PH_SYS;
                end
            PH_TOOL:
            begin
                idle    = done_i.tool_idle;
                win_end = idle || (s_r.win_ms >= win_cap);
                if (win_end)
                begin
                    s_nxt.win_ms = '0;
                    s_nxt.phase  = PH_SYS;
                end
            end
            PH_SYS:
            begin
                idle    = done_i.sys_idle;
                win_end = idle || (s_r.win_ms >= win_cap);
                if (win_end)
                    s_nxt.phase = PH_DIAG;
            end
            PH_DIAG:
                if (done_i.diag_done)
                begin
                    if (s_r.const_act && (s_r.scan_ms > s_r.const_len))
                        s_nxt.ovr_seen = 1'b1;
                    else if (s_r.const_act && !s_r.alarm_done)
                        s_nxt.flag = 1'b0;
                    if (s_r.stop_pend)
                    begin
                        s_nxt.mode      = cfg_i.stop_io_scan ? MD_STOP_IO : MD_STOP_NIO;
                        s_nxt.out_dflt  = 1'b1;
                        s_nxt.diag      = 1'b1;
                        s_nxt.stop_pend = 1'b0;
                    end
                    s_nxt.phase = PH_WAIT;
                end
            PH_WAIT:
                // constant mode waits for the scan length
                if (!s_r.const_act || s_r.scan_ms >= s_r.const_len)
                    s_nxt.phase = PH_HOUSE;
            default:
                s_nxt.phase = PH_HOUSE;
        endcase

        if (svc_stop_i && !stopped)
            s_nxt.stop_pend = 1'b1;

        // run/stop control
        if (stop_req_i && !stopped)
        begin
            s_nxt.mode     = cfg_i.stop_io_scan ? MD_STOP_IO : MD_STOP_NIO;
            s_nxt.out_dflt = 1'b1;
        end
        if (s_r.sw_mode_en && sw_fall && !stopped)
        begin
            s_nxt.mode     = cfg_i.stop_io_scan ? MD_STOP_IO : MD_STOP_NIO;
            s_nxt.out_dflt = 1'b1;
        end
        if (stopped && s_r.mode != MD_FAULT && !fatal_fault_i
            && (!s_r.sw_mode_en || sw_s2_r)
            && (run_req_i || (s_r.sw_mode_en && sw_rise)))
        begin
            s_nxt.mode     = MD_RUN;
            s_nxt.out_dflt = 1'b0;
        end

        // fault-clearing blink window
        if (s_r.mode == MD_FAULT && s_r.sw_mode_en && !s_r.blinking && sw_rise
            && fatal_fault_i)
        begin
            s_nxt.blinking = 1'b1;
            s_nxt.blink_ms = '0;
            s_nxt.hold_ms  = '0;
            s_nxt.tstep    = 2'h0;
        end
        if (s_r.blinking)
        begin
            if (tick)
                s_nxt.blink_ms = s_r.blink_ms + MSW'(1);
            if (s_r.tstep == 2'h0 && sw_fall)
            begin
                s_nxt.tstep   = (s_r.hold_ms >= HLD_LEN) ? 2'h1 : 2'h0;
                s_nxt.hold_ms = '0;
            end
            else if (s_r.tstep == 2'h1 && sw_rise)
            begin
                if (s_r.hold_ms >= HLD_LEN)
                begin
                    s_nxt.fclr     = 1'b1;
                    s_nxt.mode     = MD_RUN;
                    s_nxt.out_dflt = 1'b0;
                    s_nxt.blinking = 1'b0;
                end
                else
                begin
                    s_nxt.tstep   = 2'h0;
                    s_nxt.hold_ms = '0;
                end
            end
            else if (s_r.tstep == 2'h0 && sw_rise)
                s_nxt.hold_ms = '0;
            if (s_r.blink_ms >= BLK_LEN && s_nxt.blinking)
                s_nxt.blinking = 1'b0;
        end

        // watchdog in standard mode
        if (!s_r.const_act && s_r.scan_ms >= WD_LEN && s_r.phase != PH_WAIT)
        begin
            s_nxt.ok_led   = 1'b0;
            s_nxt.wd_rst   = 1'b1;
            s_nxt.wd_fault = 1'b1;
            s_nxt.mode     = MD_FAULT;
            s_nxt.out_dflt = 1'b1;
            s_nxt.phase    = PH_HOUSE;
            s_nxt.scan_ms  = '0;
            s_nxt.blinking = 1'b0;
        end
        else if (s_r.phase == PH_HOUSE)
            s_nxt.ok_led = 1'b1;

        // indicators and protection
        if (s_nxt.blinking)
            s_nxt.run_led = (s_r.blink_ms / BLK_HF) % MSW'(2) == '0;
        else
            s_nxt.run_led = (s_nxt.mode == MD_RUN);
        s_nxt.wr_ok = !(s_r.sw_prot_en && !sw_s2_r) && mem_wr_req_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_r            <= '0;
            s_r.phase      <= PH_HOUSE;
            s_r.mode       <= MD_STOP_NIO;
            s_r.sw_mode_en <= 1'b1;
            s_r.const_len  <= MSW'(CONST_MAX_MS);
            s_r.out_dflt   <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign phase_o             = s_r.phase;
    assign mode_o              = s_r.mode;
    assign scan_start_o        = s_r.scan_start;
    assign scan_overrun_flag_o = s_r.flag;
    assign ovr_alarm_o         = s_r.alarm;
    assign wd_fault_o          = s_r.wd_fault;
    assign wd_reset_o          = s_r.wd_rst;
    assign diag_log_o          = s_r.diag;
    assign faults_clr_o        = s_r.fclr;
    assign out_default_o       = s_r.out_dflt;
    assign ok_led_o            = s_r.ok_led;
    assign run_led_o           = s_r.run_led;
    assign mem_wr_ok_o         = s_r.wr_ok;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_diag_end;
        s_r.phase == PH_DIAG && done_i.diag_done;
    endsequence

    a_phase_order: assert property (s_r.phase == PH_INPUT |=> s_r.phase inside {PH_INPUT, PH_EXEC, PH_OUTPUT, PH_HOUSE}) else $error("bad phase after input");
    a_exec_skip: assert property (s_r.phase == PH_EXEC |-> s_r.mode == MD_RUN || $past(s_r.mode) == MD_RUN) else $error("exec while stopped");
    a_window_cap: assert property (s_r.phase inside {PH_TOOL, PH_SYS} |-> s_r.win_ms <= WIN_RTC + MSW'(1)) else $error("window too long");
    a_scan_start: assert property (s_r.phase == PH_HOUSE && !s_r.wd_rst |=> s_r.scan_start && s_r.scan_ms == '0) else $error("scan start missing");
    a_wd_stop: assert property (s_r.wd_fault |-> s_r.mode == MD_FAULT && !s_r.ok_led) else $error("watchdog without stop");
    a_const_wait: assert property (s_r.phase == PH_WAIT && s_r.const_act && s_r.scan_ms < s_r.const_len && !(!s_r.const_act && s_r.scan_ms >= WD_LEN) |=> s_r.phase == PH_WAIT) else $error("wait ended early");
    a_flag_clear: assert property (!s_r.const_act |=> !s_r.flag) else $error("flag kept outside constant");
    a_stop_call: assert property (s_diag_end ##0 s_r.stop_pend |=> s_r.mode != MD_RUN && s_r.diag && s_r.out_dflt) else $error("stop call ignored");
    a_sw_refuse: assert property (s_r.sw_mode_en && !sw_s2_r && s_r.mode != MD_RUN |=> s_r.mode != MD_RUN) else $error("run while switch at stop");
    a_protect: assert property (s_r.sw_prot_en && !sw_s2_r |=> !s_r.wr_ok) else $error("write not blocked");
endmodule : scs_sequencer

// *** testbench/scs_far_model.sv ***
// far-side model: option modules, tool and diagnostics answering phase handshakes
`timescale 1ns/100ps
module scs_far_model
    import scs_pkg::*;
(
    input  wire logic       clk_i,   // system clock
    input  scs_phase_t      phase_i, // phase shown by the sequencer
    input  scs_done_t       hold_i,  // completions withheld by the bench
    input  wire logic [7:0] dly_i,   // cycles spent before completing
    output scs_done_t       done_o   // completion levels
);
    logic [7:0] cnt;
    scs_phase_t last;
    logic       rdy;

    initial
    begin
        cnt = 8'h00;
        last = PH_HOUSE;
        done_o = '0;
    end

    // =========================================================
    // completion only inside its own phase, dropped on leaving
    // =========================================================
    always @(negedge clk_i)
    begin
        rdy = (phase_i == last) && (cnt >= dly_i);
        cnt <= (phase_i == last && cnt != 8'hff) ? cnt + 8'h01 : 8'h00;
        last <= phase_i;
        done_o <= {phase_i[1], phase_i[2], phase_i[3], phase_i[4], phase_i[5], phase_i[6]}
                  & {6{rdy}} & ~hold_i;
    end
endmodule : scs_far_model

// *** testbench/testbench.sv ***
// self-checking bench for the scan-cycle sequencer
`timescale 1ns/100ps
module testbench;
    import scs_pkg::*;
    localparam int T = 10;
    localparam int BL = 1000;
    localparam int HD = 50;
    logic       clk_i, rst_n_i, cfg_store_i, cfg_reset_i, tool_attached_i, sw_run_i;
    logic       svc_stop_i, run_req_i, stop_req_i, fatal_fault_i, mem_wr_req_i;
    scs_cfg_t   cfg_i, c;
    scs_done_t  done_i, hold;
    logic [7:0] dly;
    scs_phase_t phase_o;
    scs_mode_t  mode_o;
    logic       scan_start_o, scan_overrun_flag_o, ovr_alarm_o, wd_fault_o, wd_reset_o;
    logic       diag_log_o, faults_clr_o, out_default_o, ok_led_o, run_led_o, mem_wr_ok_o;
    int         n_errors, checked, cyc, n;

    scs_sequencer #(.BLINK_MS(BL), .HOLD_T(HD), .TICK_DIV(T)) DUT (.*);
    scs_far_model FAR (.clk_i(clk_i), .phase_i(phase_o), .hold_i(hold), .dly_i(dly),
                       .done_o(done_i));

    // =========================================================
    // clock, timeout
    // =========================================================
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc >= 80000)
        begin
            n_errors++;
            stop_test();
        end
    end

    // =========================================================
    // tasks
    // =========================================================
    task stop_test;
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    task chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task tk(input int k);
        repeat (k) @(negedge clk_i);
    endtask : tk

    task store(input scs_cfg_t v);
        cfg_i = v;
        tk(1);
        cfg_store_i = 1'b1;
        tk(1);
        cfg_store_i = 1'b0;
        tk(2);
    endtask : store

    task automatic waitp(ref logic s, input int lim);
        for (int j = 0; j < lim && s !== 1'b1; j++) tk(1);
        chk(s, 1'b1);
    endtask : waitp

    task automatic waitm(input scs_mode_t m, input int lim);
        for (int j = 0; j < lim && mode_o !== m; j++) tk(1);
        chk(mode_o, m);
    endtask : waitm

    // phases of one scan, housekeeping and waits left out
    task automatic scan_seq(input logic [47:0] exp);
        logic [47:0] s;
        logic [7:0]  last;
        s = '0;
        last = '0;
        for (int j = 0; j < 9000 && scan_start_o !== 1'b1; j++) tk(1);
        for (int j = 0; j < 9000 && phase_o !== PH_HOUSE; j++)
        begin
            if (phase_o !== last && phase_o !== PH_WAIT) s = {s[39:0], phase_o};
            last = phase_o;
            tk(1);
        end
        chk(s, exp);
    endtask : scan_seq

    task automatic win(output int w);
        for (int j = 0; j < 9000 && phase_o !== PH_HOUSE; j++) tk(1);
        for (int j = 0; j < 9000 && phase_o !== PH_SYS; j++) tk(1);
        w = 0;
        while (phase_o === PH_SYS && w < 9000)
        begin
            w++;
            tk(1);
        end
    endtask : win

    task sw(input logic v);
        sw_run_i = v;
        tk(30);
    endtask : sw

    // =========================================================
    // main sequence
    // =========================================================
    initial
    begin
        {rst_n_i, cfg_store_i, cfg_reset_i, sw_run_i, svc_stop_i} = '0;
        {run_req_i, stop_req_i, fatal_fault_i, mem_wr_req_i} = '0;
        c = '{1'b0, 13'd500, 1'b0, 1'b0, 1'b1, 1'b0};
        cfg_i = c;
        hold = '0;
        dly = 8'h02;
        tool_attached_i = 1'b1;
        repeat (16) @(posedge clk_i);
        @(negedge clk_i) rst_n_i = 1'b1;
        store(c);
        scan_seq({PH_INPUT, PH_OUTPUT, PH_TOOL, PH_SYS, PH_DIAG});
        cfg_reset_i = 1'b1;
        tk(1);
        cfg_reset_i = 1'b0;
        mem_wr_req_i = 1'b1;
        tk(4);
        chk(mem_wr_ok_o, 1'b1);
        c.sw_protect_en = 1'b1;
        store(c);
        chk(mem_wr_ok_o, 1'b0);
        c.sw_protect_en = 1'b0;
        store(c);
        mem_wr_req_i = 1'b0;
        run_req_i = 1'b1;
        tk(1);
        run_req_i = 1'b0;
        tk(20);
        chk(mode_o, MD_STOP_NIO);
        sw_run_i = 1'b1;
        waitm(MD_RUN, 100);
        scan_seq({PH_INPUT, PH_EXEC, PH_OUTPUT, PH_TOOL, PH_SYS, PH_DIAG});
        tool_attached_i = 1'b0;
        scan_seq({PH_INPUT, PH_EXEC, PH_OUTPUT, PH_SYS, PH_DIAG});
        tool_attached_i = 1'b1;
        hold.sys_idle = 1'b1;
        win(n);
        chk(n >= 5 * T && n <= 6 * T + 2, 1'b1);
        hold = '0;
        sw_run_i = 1'b0;
        waitm(MD_STOP_NIO, 100);
        c.rtc_mode = 1'b1;
        c.stop_io_scan = 1'b1;
        store(c);
        scan_seq({PH_INPUT, PH_OUTPUT, PH_TOOL, PH_SYS, PH_DIAG});
        sw_run_i = 1'b1;
        waitm(MD_RUN, 100);
        hold.sys_idle = 1'b1;
        win(n);
        chk(n >= 399 * T && n <= 400 * T + 2, 1'b1);
        hold = '0;
        sw_run_i = 1'b0;
        waitm(MD_STOP_IO, 100);
        sw_run_i = 1'b1;
        waitm(MD_RUN, 100);
        svc_stop_i = 1'b1;
        tk(1);
        svc_stop_i = 1'b0;
        waitp(diag_log_o, 300);
        tk(100);
        chk(mode_o == MD_RUN, 1'b0);
        chk(out_default_o, 1'b1);
        // length of 5 ms kept about 3 ms above the plain scan time of about 2 ms in the fitting case
        c.rtc_mode = 1'b0;
        c.const_scan_dflt = 1'b1;
        c.const_len_ms = 13'd5;
        store(c);
        sw(1'b0);
        sw_run_i = 1'b1;
        waitm(MD_RUN, 100);
        dly = 8'd20;
        waitp(ovr_alarm_o, 600);
        waitp(scan_overrun_flag_o, 600);
        dly = 8'h01;
        tk(400);
        chk(scan_overrun_flag_o, 1'b0);
        for (int j = 0; j < 200 && scan_start_o !== 1'b1; j++) tk(1);
        tk(1);
        n = 1;
        for (int j = 0; j < 200 && scan_start_o !== 1'b1; j++)
        begin
            n++;
            tk(1);
        end
        chk(n > 4 * T && n <= 5 * T + 2, 1'b1);
        sw(1'b0);
        c.const_scan_dflt = 1'b0;
        store(c);
        sw_run_i = 1'b1;
        waitm(MD_RUN, 100);
        hold.exec_done = 1'b1;
        waitp(wd_fault_o, 5300);
        chk(ok_led_o, 1'b0);
        chk(wd_reset_o, 1'b1);
        tk(2);
        chk(mode_o, MD_FAULT);
        hold = '0;
        fatal_fault_i = 1'b1;
        sw(1'b0);
        sw_run_i = 1'b1;
        waitp(run_led_o, 2600);
        tk(HD * T + 5 * T);
        sw_run_i = 1'b0;
        tk(HD * T + 5 * T);
        sw_run_i = 1'b1;
        waitp(faults_clr_o, 100);
        waitm(MD_RUN, 10);
        tk(3000);
        chk(run_led_o, 1'b1);
        fatal_fault_i = 1'b0;
        hold.exec_done = 1'b1;
        waitp(wd_fault_o, 5300);
        hold = '0;
        fatal_fault_i = 1'b1;
        sw(1'b0);
        sw_run_i = 1'b1;
        tk(BL * T + 300);
        chk(run_led_o, 1'b0);
        chk(mode_o, MD_FAULT);
        stop_test();
    end
endmodule : testbench
